// >>> rtl/eprom_prog_pkg.sv
package eprom_prog_pkg;

	// ***************************************************
	// timing
	// ***************************************************
	localparam int CLK_NS = 10;
	localparam int T_PW_US = 100;
	localparam int T_PW_MIN_US = 95;
	localparam int T_PW_MAX_US = 105;
	localparam int T_LONG_US = 1000;
	localparam int T_SETUP_US = 2;
	localparam int T_ACC_NS = 300;
	localparam int PW_CYC = T_PW_US * 1000 / CLK_NS;
	localparam int PW_MIN_CYC = (T_PW_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int PW_MAX_CYC = T_PW_MAX_US * 1000 / CLK_NS;
	localparam int LONG_CYC = T_LONG_US * 1000 / CLK_NS;
	localparam int SETUP_CYC = (T_SETUP_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int OVP_FACTOR = 3;
	localparam int MAX_SHORT_PULSES = 10;
	localparam int MAX_LONG_PULSES = 25;

	// ***************************************************
	// commands, flows, states
	// ***************************************************
	localparam logic [1:0] OP_READ = 2'h0;
	localparam logic [1:0] OP_PROG = 2'h1;
	localparam logic [1:0] OP_VERIFY = 2'h2;
	localparam logic [1:0] OP_IDENT = 2'h3;
	localparam logic [1:0] ALG_EXPRESS = 2'h0;
	localparam logic [1:0] ALG_RAPID = 2'h1;
	localparam logic [1:0] ALG_FAST = 2'h2;

	typedef enum logic [2:0] {
		S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_TURN, S_VERIFY, S_READ, S_DONE
	} st_e;

	typedef struct packed {
		st_e st;
		logic [1:0] op;
		logic [1:0] algo;
		logic ovp;
		logic [4:0] pulses;
		logic [31:0] timer;
		logic [15:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic fail;
		logic done;
		logic ce_n;
		logic oe_n;
		logic oe_vh;
		logic vcc_prog;
		logic id_vh;
		logic dq_oe;
	} state_s;

endpackage

// >>> rtl/eprom_programmer.sv
// Overview of operation
// - program needs supply raised, output-gate at high level, chip select low
// - short-pulse flows give at most ten 100 us pulses, stop when verified
// - address and byte stand stable, then a chip select low pulse programs
// - each short-pulse-flow programming pulse lasts 95 to 105 us
// - verify: raised supply, chip select and output-gate low, device drives byte
// - identity: identity pin at high level, chip select and output-gate low
// - short-pulse flows verify after every pulse at the raised supply
// - long-pulse flow: up to 25 1 ms pulses then threefold overprogram pulse
// - narrow-pulse flow uses 100 us pulses and no overprogram pulse
module eprom_programmer
	import eprom_prog_pkg::*;
#(
	parameter int PULSE_CYC = PW_CYC,
	parameter int LONG_PULSE_CYC = LONG_CYC,
	parameter int MAX_SHORT = MAX_SHORT_PULSES,
	parameter int MAX_LONG = MAX_LONG_PULSES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic cmd_valid,
	output logic cmd_ready,
	input wire logic [1:0] cmd_op,
	input wire logic [1:0] cmd_algo,
	input wire logic [15:0] cmd_addr,
	input wire logic [7:0] cmd_data,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_fail,
	output logic [4:0] rsp_pulses,
	output logic [15:0] address_pins,
	output logic [7:0] data_pins_o,
	output logic data_pins_oe,
	input wire logic [7:0] data_pins_i,
	output logic ce_n,
	output logic oe_n,
	output logic oe_prog_high,
	output logic vcc_prog,
	output logic identity_enable_pin_high
);

	// ***************************************************
	// helpers
	// ***************************************************
	function automatic logic [4:0] max_pulses(input logic [1:0] algo);
		max_pulses = (algo == ALG_FAST) ? 5'(MAX_LONG) : 5'(MAX_SHORT);
	endfunction

	function automatic logic [31:0] pulse_len(input logic [1:0] algo);
		pulse_len = (algo == ALG_FAST) ? 32'(LONG_PULSE_CYC - 1) : 32'(PULSE_CYC - 1);
	endfunction

	// ***************************************************
	// state
	// ***************************************************
	state_s s_ff;
	state_s nxt_s;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		if (s_ff.timer != 32'h0) begin
			nxt_s.timer = s_ff.timer - 32'h1;
		end
		case (s_ff.st)
			S_IDLE: begin
				if (cmd_valid) begin
					nxt_s.op = cmd_op;
					nxt_s.algo = cmd_algo;
					nxt_s.addr = cmd_addr;
					nxt_s.wdata = cmd_data;
					nxt_s.pulses = 5'h0;
					nxt_s.ovp = 1'b0;
					nxt_s.fail = 1'b0;
					if (cmd_op == OP_PROG) begin
						// address, byte and supplies settle before chip select drops
						nxt_s.vcc_prog = 1'b1;
						nxt_s.oe_vh = 1'b1;
						nxt_s.dq_oe = 1'b1;
						nxt_s.timer = 32'(SETUP_CYC - 1);
						nxt_s.st = S_SETUP;
					end else begin
						// read, verify or identity: both strobes low
						nxt_s.vcc_prog = (cmd_op == OP_VERIFY);
						nxt_s.id_vh = (cmd_op == OP_IDENT);
						nxt_s.ce_n = 1'b0;
						nxt_s.oe_n = 1'b0;
						nxt_s.timer = 32'(ACC_CYC - 1);
						nxt_s.st = S_READ;
					end
				end
			end
			S_SETUP: begin
				if (!s_ff.oe_vh) begin
					// chip select is already back high: raise the gate level a cycle later
					nxt_s.oe_vh = 1'b1;
					nxt_s.dq_oe = 1'b1;
					nxt_s.timer = 32'(SETUP_CYC - 1);
				end else if (s_ff.timer == 32'h0) begin
					nxt_s.ce_n = 1'b0;
					if (s_ff.ovp) begin
						// threefold the time spent on pulses so far
						nxt_s.timer = 32'(OVP_FACTOR * 32'(s_ff.pulses) * LONG_PULSE_CYC - 1);
					end else begin
						nxt_s.timer = pulse_len(s_ff.algo);
					end
					nxt_s.st = S_PULSE;
				end
			end
			S_PULSE: begin
				if (s_ff.timer == 32'h0) begin
					nxt_s.ce_n = 1'b1;
					if (!s_ff.ovp) begin
						nxt_s.pulses = s_ff.pulses + 5'h1;
					end
					nxt_s.timer = 32'(SETUP_CYC - 1);
					nxt_s.st = S_HOLD;
				end
			end
			S_HOLD: begin
				if (s_ff.timer == 32'h0) begin
					// data released, programming level removed before gating out
					nxt_s.dq_oe = 1'b0;
					nxt_s.oe_vh = 1'b0;
					nxt_s.timer = 32'(SETUP_CYC - 1);
					nxt_s.st = s_ff.ovp ? S_DONE : S_TURN;
				end
			end
			S_TURN: begin
				if (s_ff.timer == 32'h0) begin
					nxt_s.ce_n = 1'b0;
					nxt_s.oe_n = 1'b0;
					nxt_s.timer = 32'(ACC_CYC - 1);
					nxt_s.st = S_VERIFY;
				end
			end
			S_VERIFY: begin
				if (s_ff.timer == 32'h0) begin
					nxt_s.rdata = data_pins_i;
					nxt_s.ce_n = 1'b1;
					nxt_s.oe_n = 1'b1;
					if (data_pins_i == s_ff.wdata) begin
						if (s_ff.algo == ALG_FAST) begin
							nxt_s.ovp = 1'b1;
							nxt_s.timer = 32'(SETUP_CYC - 1);
							nxt_s.st = S_SETUP;
						end else begin
							nxt_s.st = S_DONE;
						end
					end else if (s_ff.pulses < max_pulses(s_ff.algo)) begin
						nxt_s.timer = 32'(SETUP_CYC - 1);
						nxt_s.st = S_SETUP;
					end else begin
						nxt_s.fail = 1'b1;
						nxt_s.st = S_DONE;
					end
				end
			end
			S_READ: begin
				if (s_ff.timer == 32'h0) begin
					nxt_s.rdata = data_pins_i;
					nxt_s.fail = (s_ff.op == OP_VERIFY) && (data_pins_i != s_ff.wdata);
					nxt_s.ce_n = 1'b1;
					nxt_s.oe_n = 1'b1;
					nxt_s.st = S_DONE;
				end
			end
			S_DONE: begin
				// back to standby at normal supply
				nxt_s.vcc_prog = 1'b0;
				nxt_s.oe_vh = 1'b0;
				nxt_s.id_vh = 1'b0;
				nxt_s.ce_n = 1'b1;
				nxt_s.oe_n = 1'b1;
				nxt_s.dq_oe = 1'b0;
				nxt_s.done = 1'b1;
				nxt_s.st = S_IDLE;
			end
			default: begin
				nxt_s.st = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_ff <= '{st: S_IDLE, op: 2'h0, algo: 2'h0, ovp: 1'b0, pulses: 5'h0,
				timer: 32'h0, addr: 16'h0, wdata: 8'hFF, rdata: 8'h0, fail: 1'b0,
				done: 1'b0, ce_n: 1'b1, oe_n: 1'b1, oe_vh: 1'b0, vcc_prog: 1'b0,
				id_vh: 1'b0, dq_oe: 1'b0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ***************************************************
	// outputs
	// ***************************************************
	assign cmd_ready = (s_ff.st == S_IDLE);
	assign rsp_valid = s_ff.done;
	assign rsp_data = s_ff.rdata;
	assign rsp_fail = s_ff.fail;
	assign rsp_pulses = s_ff.pulses;
	assign address_pins = s_ff.addr;
	assign data_pins_o = s_ff.wdata;
	assign data_pins_oe = s_ff.dq_oe;
	assign ce_n = s_ff.ce_n;
	assign oe_n = s_ff.oe_n;
	assign oe_prog_high = s_ff.oe_vh;
	assign vcc_prog = s_ff.vcc_prog;
	assign identity_enable_pin_high = s_ff.id_vh;

	// ***************************************************
	// checks
	// ***************************************************
	localparam int VFY_BOUND = 500;
	logic [31:0] low_cnt_ff;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			low_cnt_ff <= 32'h0;
		end else begin
			low_cnt_ff <= ce_n ? 32'h0 : low_cnt_ff + 32'h1;
		end
	end

	property p_prog_mode;
		@(posedge ref_clk) disable iff (!rstn)
		$fell(ce_n) && oe_prog_high |-> vcc_prog && oe_n && data_pins_oe;
	endproperty
	a_prog_mode: assert property (p_prog_mode) else $error("pulse without program mode");

	property p_pulse_width;
		@(posedge ref_clk) disable iff (!rstn)
		$rose(ce_n) && oe_prog_high && !s_ff.ovp && s_ff.algo != ALG_FAST
			|-> low_cnt_ff >= 32'(PW_MIN_CYC) && low_cnt_ff <= 32'(PW_MAX_CYC);
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("pulse width out of range");

	property p_stable_pins;
		@(posedge ref_clk) disable iff (!rstn)
		!ce_n && oe_prog_high |-> $stable(address_pins) && $stable(data_pins_o);
	endproperty
	a_stable_pins: assert property (p_stable_pins) else $error("pins moved during pulse");

	property p_max_pulses;
		@(posedge ref_clk) disable iff (!rstn)
		s_ff.pulses <= max_pulses(s_ff.algo);
	endproperty
	a_max_pulses: assert property (p_max_pulses) else $error("too many pulses");

	sequence s_pulse_end;
		$rose(ce_n) && oe_prog_high && !s_ff.ovp;
	endsequence
	sequence s_verify_reached;
		##[1:VFY_BOUND] (s_ff.st == S_VERIFY && !ce_n && !oe_n && vcc_prog && !oe_prog_high);
	endsequence
	property p_verify_after_pulse;
		@(posedge ref_clk) disable iff (!rstn)
		s_pulse_end |-> s_verify_reached;
	endproperty
	a_verify_after_pulse: assert property (p_verify_after_pulse) else $error("no verify");

	property p_verify_mode;
		@(posedge ref_clk) disable iff (!rstn)
		!oe_n && vcc_prog |-> !ce_n && !oe_prog_high && !data_pins_oe;
	endproperty
	a_verify_mode: assert property (p_verify_mode) else $error("bad verify pins");

	property p_ident;
		@(posedge ref_clk) disable iff (!rstn)
		identity_enable_pin_high && s_ff.st == S_READ |-> !ce_n && !oe_n && !vcc_prog;
	endproperty
	a_ident: assert property (p_ident) else $error("bad identity pins");

	property p_fail_report;
		@(posedge ref_clk) disable iff (!rstn)
		rsp_valid && rsp_fail && s_ff.op == OP_PROG |-> rsp_pulses == max_pulses(s_ff.algo);
	endproperty
	a_fail_report: assert property (p_fail_report) else $error("early failure");

	property p_no_ovp;
		@(posedge ref_clk) disable iff (!rstn)
		s_ff.ovp |-> s_ff.algo == ALG_FAST;
	endproperty
	a_no_ovp: assert property (p_no_ovp) else $error("overprogram in short flow");

	property p_ovp_len;
		@(posedge ref_clk) disable iff (!rstn)
		$rose(ce_n) && oe_prog_high && s_ff.ovp
			|-> low_cnt_ff == 32'(OVP_FACTOR * 32'(s_ff.pulses) * LONG_PULSE_CYC);
	endproperty
	a_ovp_len: assert property (p_ovp_len) else $error("overprogram length wrong");

endmodule

// >>> test/eprom_model.sv
module eprom_model #(
	parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
	parameter logic [7:0] DEVICE_CODE = 8'h3C // arbitrary value
) (
	input wire logic [15:0] address_pins,
	input wire logic [7:0] host_data,
	input wire logic host_oe,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic oe_prog_high,
	input wire logic vcc_prog,
	input wire logic identity_enable_pin_high,
	input wire logic pw_check,
	input int need,
	output logic [7:0] data_pins,
	output logic dev_drive,
	output int bad
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	int tries [0:65535];
	logic [7:0] last;
	logic [7:0] dev_val;
	realtime t_fall;
	initial begin
		foreach (mem[i]) begin
			mem[i] = 8'hFF;
			tries[i] = 0;
		end
		bad = 0;
		last = 8'hFF;
		t_fall = 0;
	end
	always @(negedge ce_n) t_fall = $realtime;
	// ***************************************************
	// programming: a cell only takes after need pulses
	// ***************************************************
	always @(posedge ce_n) begin
		if (vcc_prog && oe_prog_high) begin
			if (pw_check && ($realtime - t_fall < 95000.0 || $realtime - t_fall > 105000.0))
				bad++;
			if (host_oe !== 1'b1) bad++;
			tries[address_pins]++;
			if (tries[address_pins] >= need)
				mem[address_pins] = mem[address_pins] & host_data;
		end
	end
	// ***************************************************
	// output drive
	// ***************************************************
	assign dev_drive = !ce_n && !oe_n && !oe_prog_high;
	assign dev_val = identity_enable_pin_high ?
		(address_pins[0] ? DEVICE_CODE : MAKER_CODE) : mem[address_pins];
	always @* begin
		if (dev_drive) last = dev_val;
		else if (host_oe) last = host_data;
	end
	// released bus shows the inverse of the last level, never a stale byte
	assign data_pins = dev_drive ? dev_val : (host_oe ? host_data : ~last);
endmodule

// >>> test/tb_top.sv
module tb_top
	import eprom_prog_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int NSHORT = 3;
	localparam logic [7:0] MAKER = 8'hA5; // arbitrary value
	localparam logic [7:0] DEVICE = 8'h3C; // arbitrary value
	logic ref_clk, rstn, cmd_valid, cmd_ready, rsp_valid, rsp_fail, pw_check;
	logic [1:0] cmd_op, cmd_algo;
	logic [15:0] cmd_addr, address_pins;
	logic [7:0] cmd_data, rsp_data, data_pins_o, data_pins_i;
	logic [4:0] rsp_pulses;
	logic data_pins_oe, ce_n, oe_n, oe_prog_high, vcc_prog, identity_enable_pin_high;
	logic dev_drive;
	int err_count, n_compared, need, bad;
	eprom_programmer #(.LONG_PULSE_CYC(40), .MAX_SHORT(NSHORT)) dut (
		.ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_op(cmd_op), .cmd_algo(cmd_algo), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_fail(rsp_fail),
		.rsp_pulses(rsp_pulses), .address_pins(address_pins), .data_pins_o(data_pins_o),
		.data_pins_oe(data_pins_oe), .data_pins_i(data_pins_i), .ce_n(ce_n), .oe_n(oe_n),
		.oe_prog_high(oe_prog_high), .vcc_prog(vcc_prog),
		.identity_enable_pin_high(identity_enable_pin_high));
	eprom_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) model (
		.address_pins(address_pins), .host_data(data_pins_o), .host_oe(data_pins_oe),
		.ce_n(ce_n), .oe_n(oe_n), .oe_prog_high(oe_prog_high), .vcc_prog(vcc_prog),
		.identity_enable_pin_high(identity_enable_pin_high), .pw_check(pw_check),
		.need(need), .data_pins(data_pins_i), .dev_drive(dev_drive), .bad(bad));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ***************************************************
	// shared tasks
	// ***************************************************
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic conclude;
		if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic run(input logic [1:0] op, input logic [1:0] alg, input logic [15:0] a,
		input logic [7:0] d);
		int i;
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_algo = alg;
		cmd_addr = a;
		cmd_data = d;
		for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) @(negedge ref_clk);
		if (i == 100) begin
			err_count++;
			conclude();
		end
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		for (i = 0; i < 40000 && rsp_valid !== 1'b1; i++) @(negedge ref_clk);
		if (i == 40000) begin
			err_count++;
			conclude();
		end
	endtask
	always @(negedge ref_clk) if (rstn && dev_drive && data_pins_oe) chk("contention", 1, 0);
	// ***************************************************
	// scenarios
	// ***************************************************
	task automatic t_reset;
		chk("ce_n", ce_n, 1);
		chk("oe_n", oe_n, 1);
		chk("raised", {oe_prog_high, vcc_prog, identity_enable_pin_high, data_pins_oe}, 0);
		chk("ready", cmd_ready, 1);
	endtask
	task automatic t_program;
		run(OP_READ, ALG_EXPRESS, 16'hFFFF, 8'h00);
		chk("erased", rsp_data, 8'hFF);
		run(OP_PROG, ALG_EXPRESS, 16'h1234, 8'hA5);
		chk("express", {rsp_fail, rsp_pulses}, {1'b0, 5'd1});
		run(OP_VERIFY, ALG_EXPRESS, 16'h1234, 8'hA5);
		chk("verify", {rsp_fail, rsp_data}, {1'b0, 8'hA5});
		run(OP_PROG, ALG_EXPRESS, 16'h1234, 8'h5A);
		chk("retry", {rsp_fail, rsp_pulses}, {1'b1, 5'(NSHORT)});
		run(OP_READ, ALG_EXPRESS, 16'h1234, 8'h00);
		chk("one to zero", rsp_data, 8'h00);
	endtask
	task automatic t_algos;
		need = 2;
		run(OP_PROG, ALG_RAPID, 16'h2000, 8'h3C);
		chk("rapid", {rsp_fail, rsp_pulses}, {1'b0, 5'd2});
		pw_check = 1'b0;
		run(OP_PROG, ALG_FAST, 16'h3000, 8'h81);
		chk("fast", {rsp_fail, rsp_pulses}, {1'b0, 5'd2});
		run(OP_READ, ALG_FAST, 16'h3000, 8'h00);
		chk("fast data", rsp_data, 8'h81);
	endtask
	task automatic t_ident;
		run(OP_IDENT, ALG_EXPRESS, 16'h0000, 8'h00);
		chk("maker", rsp_data, MAKER);
		run(OP_IDENT, ALG_EXPRESS, 16'h0001, 8'h00);
		chk("device", rsp_data, DEVICE);
		run(OP_VERIFY, ALG_EXPRESS, 16'h1234, 8'hFF);
		chk("mismatch", {rsp_fail, rsp_data}, {1'b1, 8'h00});
	endtask
	initial begin
		err_count = 0;
		n_compared = 0;
		need = 1;
		pw_check = 1'b1;
		rstn = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = OP_READ;
		cmd_algo = ALG_EXPRESS;
		cmd_addr = 16'h0000;
		cmd_data = 8'h00;
		repeat (12) @(negedge ref_clk);
		t_reset();
		rstn = 1'b1;
		t_program();
		t_algos();
		t_ident();
		chk("device side", bad, 0);
		conclude();
	end
endmodule
